// ==== include/ufc_regs.svh ====
// offsets, fields, reset values and timing counts of the flow-control block
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH
// avalon word offsets (byte address = 4 * index)
`define UFC_OFS_IER      4'h0
`define UFC_OFS_ISR      4'h1
`define UFC_OFS_EFR      4'h2
`define UFC_OFS_MCR      4'h3
`define UFC_OFS_LCR      4'h4
`define UFC_OFS_MSR      4'h5
`define UFC_OFS_RESUME1  4'h6
`define UFC_OFS_RESUME2  4'h7
`define UFC_OFS_PAUSE1   4'h8
`define UFC_OFS_PAUSE2   4'h9
`define UFC_OFS_SWMODE   4'hA
`define UFC_OFS_STATUS   4'hB
// field positions
`define UFC_IER_SLEEP    4
`define UFC_IER_PAUSE    5
`define UFC_EFR_SPECIAL  5
`define UFC_EFR_AUTO_RTS 6
`define UFC_EFR_AUTO_CTS 7
`define UFC_MCR_RTS      1
`define UFC_MCR_IR_INV   2
`define UFC_MCR_IR_EN    6
`define UFC_ISR_PAUSE    4
// reset values
`define UFC_CHAR_RST     8'h00
`define UFC_REG_RST      8'h00
// timing: ticks per bit, infrared pulse in ticks
`define UFC_BIT_TICKS    16
`define UFC_IR_TICKS     3
`define UFC_PAUSE_CHARS  2
`endif

// ==== include/ufc_pkg.sv ====
// types of the flow-control block
package ufc_pkg;
    typedef enum logic [3:0] {
        UFC_SL_RUN   = 4'b0001,
        UFC_SL_SLEEP = 4'b0010,
        UFC_SL_WAKE  = 4'b0100,
        UFC_SL_HOLD  = 4'b1000
    } ufc_sleep_t;

    typedef enum logic [3:0] {
        UFC_TX_IDLE  = 4'b0001,
        UFC_TX_WAIT  = 4'b0010,
        UFC_TX_SEND1 = 4'b0100,
        UFC_TX_SEND2 = 4'b1000
    } ufc_txfc_t;

    // software flow-control mode
    typedef struct packed {
        logic double_char;
        logic rx_en;
        logic tx_en;
    } ufc_swmode_t;

    // received character from core
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ufc_char_t;
endpackage

// ==== hdl/ufc_flow.sv ====
// flow control, special char, infrared and sleep logic of one serial channel
`timescale 1ns/1ps
`include "ufc_regs.svh"
module ufc_flow #(
    parameter int FIFO_AW = 5
) (
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic [5:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               sample_tick,
    input  wire logic [FIFO_AW-1:0] rx_fill,
    input  wire logic [1:0]         rx_trigger_sel,
    input  wire ufc_pkg::ufc_char_t rx_char,
    input  wire logic               tx_char_done,
    input  wire logic               tx_shift_busy,
    input  wire logic               tx_serial,
    input  wire logic               thr_write,
    input  wire logic               other_irq_pending,
    input  wire logic               other_sleep_en,
    input  wire logic               core_irq_pending,
    input  wire logic               rx_pin,
    input  wire logic               cts_in_n,
    input  wire logic               dsr_in_n,
    input  wire logic               carrier_detect_in_n,
    input  wire logic               ring_indicator_in_n,
    output logic                    rts_out_n,
    output logic                    tx_pin,
    output logic                    rx_data,
    output logic                    tx_enable,
    output logic                    rx_store,
    output logic [7:0]              rx_store_data,
    output logic                    send_req,
    output logic [7:0]              send_data,
    output logic                    flow_irq,
    output logic                    osc_enable
);
    // sampled pins
    logic [1:0] rx_s_r, cts_s_r, dsr_s_r, cd_s_r, ri_s_r;
    logic [3:0] modem_prev_r;
    // registers
    logic [7:0] ier_r, efr_r, mcr_r, lcr_r;
    logic [7:0] resume1_r, resume2_r, pause1_r, pause2_r;
    ufc_pkg::ufc_swmode_t swmode_r;
    logic [3:0] msr_delta_r;
    logic pause_flag_r, special_flag_r, paused_r, half_r, pend_first_r;
    logic rts_r, txen_r, store_r, flow_irq_r, rxd_r, txp_r, osc_r;
    logic [7:0] store_data_r;
    logic [31:0] rdata_r;
    logic wait_r;
    // tx flow sequencer
    ufc_pkg::ufc_txfc_t txs_r, txs_nxt;
    logic send_resume_r, send_resume_nxt, xoff_sent_r, xoff_sent_nxt;
    logic [15:0] dly_r, dly_nxt;
    logic req_r, req_nxt;
    logic [7:0] sdata_r, sdata_nxt;
    // infrared
    logic [4:0] ir_cnt_r, ir_cnt_nxt;
    // sleep
    ufc_pkg::ufc_sleep_t sl_r, sl_nxt;

    function automatic logic [7:0] wl_mask(input logic [1:0] wl);
        wl_mask = 8'hFF >> (2'd3 - wl);
    endfunction

    function automatic logic chr_eq(input logic [7:0] a, input logic [7:0] b, input logic [1:0] wl);
        chr_eq = ((a ^ b) & wl_mask(wl)) == 8'h00;
    endfunction

    // trigger index 0..3 -> levels 1,4,8,14
    function automatic logic [4:0] lvl(input logic [1:0] sel, input logic [1:0] which);
        logic [4:0] trig, rts_off, low;
        trig = 5'd1;
        rts_off = 5'd4;
        low = 5'd0;
        unique case (sel)
            2'd0: begin trig = 5'd1;  rts_off = 5'd4;  low = 5'd0; end
            2'd1: begin trig = 5'd4;  rts_off = 5'd8;  low = 5'd1; end
            2'd2: begin trig = 5'd8;  rts_off = 5'd14; low = 5'd4; end
            2'd3: begin trig = 5'd14; rts_off = 5'd14; low = 5'd8; end
        endcase
        lvl = (which == 2'd0) ? trig : (which == 2'd1) ? rts_off : low;
    endfunction

    logic [4:0] fill5, trig_lvl, off_lvl, low_lvl;
    assign fill5    = 5'(rx_fill);
    assign trig_lvl = lvl(rx_trigger_sel, 2'd0);
    assign off_lvl  = lvl(rx_trigger_sel, 2'd1);
    assign low_lvl  = lvl(rx_trigger_sel, 2'd2);

    // avalon slave: one wait cycle then the answer
    logic acc, wr_go, rd_go;
    assign acc   = (avs_read | avs_write) & wait_r;
    assign wr_go = avs_write & ~wait_r;
    assign rd_go = avs_read & wait_r;
    logic [3:0] widx;
    assign widx = avs_address[5:2];

    // receive character matching
    logic [7:0] rc;
    logic [1:0] wl;
    assign rc = rx_char.data;
    assign wl = lcr_r[1:0];
    logic p_first, r_first, p_double, r_double, hit_pause, hit_resume;
    assign p_first   = chr_eq(rc, pause1_r, wl);
    assign r_first   = chr_eq(rc, resume1_r, wl);
    assign p_double  = half_r & ~pend_first_r & chr_eq(rc, pause2_r, wl);
    assign r_double  = half_r & pend_first_r & chr_eq(rc, resume2_r, wl);
    assign hit_pause = rx_char.valid & swmode_r.rx_en &
                       (swmode_r.double_char ? p_double : p_first);
    assign hit_resume = rx_char.valid & swmode_r.rx_en & paused_r &
                        (swmode_r.double_char ? r_double : r_first);
    logic first_half;
    assign first_half = rx_char.valid & swmode_r.rx_en & swmode_r.double_char & ~half_r &
                        (p_first | (paused_r & r_first));
    logic special_hit;
    assign special_hit = rx_char.valid & efr_r[`UFC_EFR_SPECIAL] & chr_eq(rc, pause2_r, wl);
    logic modem_change;
    assign modem_change = |({cts_s_r[1], dsr_s_r[1], cd_s_r[1], ri_s_r[1]} ^ modem_prev_r);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s_r <= 2'b11; cts_s_r <= 2'b11; dsr_s_r <= 2'b11; cd_s_r <= 2'b11; ri_s_r <= 2'b11;
            modem_prev_r <= 4'hF;
            ier_r <= `UFC_REG_RST; efr_r <= `UFC_REG_RST; mcr_r <= `UFC_REG_RST; lcr_r <= `UFC_REG_RST;
            resume1_r <= `UFC_CHAR_RST; resume2_r <= `UFC_CHAR_RST;
            pause1_r <= `UFC_CHAR_RST; pause2_r <= `UFC_CHAR_RST;
            swmode_r <= '0; msr_delta_r <= 4'h0;
            pause_flag_r <= 1'b0; special_flag_r <= 1'b0; paused_r <= 1'b0;
            half_r <= 1'b0; pend_first_r <= 1'b0;
            rts_r <= 1'b0; txen_r <= 1'b1; store_r <= 1'b0; store_data_r <= 8'h00;
            flow_irq_r <= 1'b0; rxd_r <= 1'b1; txp_r <= 1'b1; osc_r <= 1'b1;
            rdata_r <= 32'h0000_0000; wait_r <= 1'b1;
        end else begin
            rx_s_r <= {rx_s_r[0], rx_pin};
            cts_s_r <= {cts_s_r[0], cts_in_n};
            dsr_s_r <= {dsr_s_r[0], dsr_in_n};
            cd_s_r <= {cd_s_r[0], carrier_detect_in_n};
            ri_s_r <= {ri_s_r[0], ring_indicator_in_n};
            modem_prev_r <= {cts_s_r[1], dsr_s_r[1], cd_s_r[1], ri_s_r[1]};
            wait_r <= ~acc;
            if (wr_go && avs_byteenable[0]) begin
                unique case (widx)
                    `UFC_OFS_IER:     ier_r <= avs_writedata[7:0];
                    `UFC_OFS_EFR:     efr_r <= avs_writedata[7:0];
                    `UFC_OFS_MCR:     mcr_r <= avs_writedata[7:0];
                    `UFC_OFS_LCR:     lcr_r <= avs_writedata[7:0];
                    `UFC_OFS_RESUME1: resume1_r <= avs_writedata[7:0];
                    `UFC_OFS_RESUME2: resume2_r <= avs_writedata[7:0];
                    `UFC_OFS_PAUSE1:  pause1_r <= avs_writedata[7:0];
                    `UFC_OFS_PAUSE2:  pause2_r <= avs_writedata[7:0];
                    `UFC_OFS_SWMODE:  swmode_r <= avs_writedata[2:0];
                    default: ;
                endcase
            end
            if (rd_go) begin
                unique case (widx)
                    `UFC_OFS_IER:     rdata_r <= {24'h00_0000, ier_r};
                    `UFC_OFS_ISR:     rdata_r <= {27'h000_0000, pause_flag_r | special_flag_r, 4'h0};
                    `UFC_OFS_EFR:     rdata_r <= {24'h00_0000, efr_r};
                    `UFC_OFS_MCR:     rdata_r <= {24'h00_0000, mcr_r};
                    `UFC_OFS_LCR:     rdata_r <= {24'h00_0000, lcr_r};
                    `UFC_OFS_MSR:     rdata_r <= {24'h00_0000, ~cts_s_r[1], ~dsr_s_r[1], ~ri_s_r[1],
                                                  ~cd_s_r[1], msr_delta_r};
                    `UFC_OFS_RESUME1: rdata_r <= {24'h00_0000, resume1_r};
                    `UFC_OFS_RESUME2: rdata_r <= {24'h00_0000, resume2_r};
                    `UFC_OFS_PAUSE1:  rdata_r <= {24'h00_0000, pause1_r};
                    `UFC_OFS_PAUSE2:  rdata_r <= {24'h00_0000, pause2_r};
                    `UFC_OFS_SWMODE:  rdata_r <= {29'h0000_0000, swmode_r};
                    `UFC_OFS_STATUS:  rdata_r <= {27'h000_0000, sl_r == ufc_pkg::UFC_SL_SLEEP, paused_r,
                                                  special_flag_r, pause_flag_r, rts_r};
                    default:          rdata_r <= 32'h0000_0000;
                endcase
            end
            // modem deltas: change sets, status read clears, set wins
            msr_delta_r <= ((rd_go && widx == `UFC_OFS_MSR) ? 4'h0 : msr_delta_r) |
                           ({cts_s_r[1], dsr_s_r[1], cd_s_r[1], ri_s_r[1]} ^ modem_prev_r);
            // double-character tracking
            if (rx_char.valid) begin
                half_r <= first_half;
                pend_first_r <= paused_r & r_first & ~p_first;
            end
            if (hit_pause) begin
                paused_r <= 1'b1;
            end else if (hit_resume) begin
                paused_r <= 1'b0;
            end
            // pause flag: a set beats the clears
            if (hit_pause && ier_r[`UFC_IER_PAUSE]) begin
                pause_flag_r <= 1'b1;
            end else if (hit_resume || (rd_go && widx == `UFC_OFS_ISR)) begin
                pause_flag_r <= 1'b0;
            end
            if (special_hit) begin
                special_flag_r <= 1'b1;
            end else if (hit_resume || (rd_go && widx == `UFC_OFS_ISR)) begin
                special_flag_r <= 1'b0;
            end
            // flow chars are swallowed unless special detect keeps the pause2 match
            store_r <= rx_char.valid & ~((hit_pause | hit_resume | first_half) & ~special_hit);
            store_data_r <= rc;
            flow_irq_r <= pause_flag_r | special_flag_r;
            // auto rts with hysteresis; software rts bit starts it
            if (!mcr_r[`UFC_MCR_RTS]) begin
                rts_r <= 1'b0;
            end else if (!efr_r[`UFC_EFR_AUTO_RTS]) begin
                rts_r <= 1'b1;
            end else if (fill5 >= off_lvl) begin
                rts_r <= 1'b0;
            end else if (fill5 <= low_lvl) begin
                rts_r <= 1'b1;
            end
            // gate moves between characters so the shift register finishes
            if (!tx_shift_busy || tx_char_done) begin
                txen_r <= ~((efr_r[`UFC_EFR_AUTO_CTS] & cts_s_r[1]) | paused_r);
            end
            // infrared rx: optional invert, light pulse reads low
            if (mcr_r[`UFC_MCR_IR_EN]) begin
                rxd_r <= ~(rx_s_r[1] ^ mcr_r[`UFC_MCR_IR_INV]);
            end else begin
                rxd_r <= rx_s_r[1];
            end
            if (mcr_r[`UFC_MCR_IR_EN]) begin
                txp_r <= (ir_cnt_r != 5'd0) & (ir_cnt_r <= 5'(`UFC_IR_TICKS));
            end else begin
                txp_r <= tx_serial;
            end
            osc_r <= (sl_nxt != ufc_pkg::UFC_SL_SLEEP);
        end
    end

    // infrared encoder: count ticks through each zero bit
    always_comb begin
        ir_cnt_nxt = ir_cnt_r;
        if (sample_tick) begin
            if (ir_cnt_r != 5'd0) begin
                ir_cnt_nxt = (ir_cnt_r == 5'(`UFC_BIT_TICKS)) ? (tx_serial ? 5'd0 : 5'd1) : ir_cnt_r + 5'd1;
            end else if (!tx_serial) begin
                ir_cnt_nxt = 5'd1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_cnt_r <= 5'd0;
        end else begin
            ir_cnt_r <= ir_cnt_nxt;
        end
    end

    // transmit pause/resume generator
    localparam logic [15:0] CHAR_TICKS = 16'(`UFC_BIT_TICKS * 10 * `UFC_PAUSE_CHARS);
    always_comb begin
        txs_nxt = txs_r;
        dly_nxt = dly_r;
        req_nxt = 1'b0;
        sdata_nxt = sdata_r;
        send_resume_nxt = send_resume_r;
        xoff_sent_nxt = xoff_sent_r;
        unique case (txs_r)
            ufc_pkg::UFC_TX_IDLE: begin
                if (swmode_r.tx_en && !xoff_sent_r && fill5 >= trig_lvl) begin
                    txs_nxt = ufc_pkg::UFC_TX_WAIT;
                    dly_nxt = CHAR_TICKS;
                end else if (xoff_sent_r && (fill5 <= low_lvl || !swmode_r.tx_en)) begin
                    txs_nxt = ufc_pkg::UFC_TX_SEND1;
                    send_resume_nxt = 1'b1;
                end
            end
            ufc_pkg::UFC_TX_WAIT: begin
                if (sample_tick) begin
                    dly_nxt = dly_r - 16'd1;
                end
                if (dly_r == 16'd0) begin
                    txs_nxt = ufc_pkg::UFC_TX_SEND1;
                    send_resume_nxt = 1'b0;
                end
            end
            ufc_pkg::UFC_TX_SEND1: begin
                req_nxt = 1'b1;
                sdata_nxt = send_resume_r ? resume1_r : pause1_r;
                if (req_r && tx_char_done) begin
                    req_nxt = swmode_r.double_char;
                    sdata_nxt = send_resume_r ? resume2_r : pause2_r;
                    txs_nxt = swmode_r.double_char ? ufc_pkg::UFC_TX_SEND2 : ufc_pkg::UFC_TX_IDLE;
                    xoff_sent_nxt = swmode_r.double_char ? xoff_sent_r : ~send_resume_r;
                end
            end
            ufc_pkg::UFC_TX_SEND2: begin
                req_nxt = 1'b1;
                if (tx_char_done) begin
                    req_nxt = 1'b0;
                    txs_nxt = ufc_pkg::UFC_TX_IDLE;
                    xoff_sent_nxt = ~send_resume_r;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            txs_r <= ufc_pkg::UFC_TX_IDLE;
            dly_r <= 16'h0000;
            req_r <= 1'b0;
            sdata_r <= 8'h00;
            send_resume_r <= 1'b0;
            xoff_sent_r <= 1'b0;
        end else begin
            txs_r <= txs_nxt;
            dly_r <= dly_nxt;
            req_r <= req_nxt;
            sdata_r <= sdata_nxt;
            send_resume_r <= send_resume_nxt;
            xoff_sent_r <= xoff_sent_nxt;
        end
    end

    // sleep: flags and deltas must clear first
    logic sleep_ok, wake_ev, rx_fall, rx_prev_r;
    assign rx_fall = rx_prev_r & ~rx_s_r[1];
    assign sleep_ok = ier_r[`UFC_IER_SLEEP] & other_sleep_en & ~core_irq_pending & ~other_irq_pending &
                      ~pause_flag_r & ~special_flag_r & (msr_delta_r == 4'h0) & rx_s_r[1];
    assign wake_ev = rx_fall | thr_write | modem_change;
    always_comb begin
        sl_nxt = sl_r;
        unique case (sl_r)
            ufc_pkg::UFC_SL_RUN:   if (sleep_ok) sl_nxt = ufc_pkg::UFC_SL_SLEEP;
            ufc_pkg::UFC_SL_SLEEP: begin
                if (wake_ev) sl_nxt = ufc_pkg::UFC_SL_WAKE;
                else if (!sleep_ok) sl_nxt = ufc_pkg::UFC_SL_RUN;
            end
            ufc_pkg::UFC_SL_WAKE:  sl_nxt = ufc_pkg::UFC_SL_HOLD;
            ufc_pkg::UFC_SL_HOLD:  if (sleep_ok && !wake_ev) sl_nxt = ufc_pkg::UFC_SL_SLEEP;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sl_r <= ufc_pkg::UFC_SL_RUN;
            rx_prev_r <= 1'b1;
        end else begin
            sl_r <= sl_nxt;
            rx_prev_r <= rx_s_r[1];
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign rts_out_n       = ~rts_r;
    assign tx_pin          = txp_r;
    assign rx_data         = rxd_r;
    assign tx_enable       = txen_r;
    assign rx_store        = store_r;
    assign rx_store_data   = store_data_r;
    assign send_req        = req_r;
    assign send_data       = sdata_r;
    assign flow_irq        = flow_irq_r;
    assign osc_enable      = osc_r;
endmodule

// ==== bench/ufc_flow_properties.sv ====
// port assertions of the flow-control block, with bind
`timescale 1ns/1ps
`include "ufc_regs.svh"
module ufc_flow_properties #(
    parameter int FIFO_AW = 5
) (
    input wire logic               core_clk, reset_n, avs_read, avs_write, avs_waitrequest,
    input wire logic [5:0]         avs_address,
    input wire logic [31:0]        avs_writedata,
    input wire logic [3:0]         avs_byteenable,
    input wire logic [FIFO_AW-1:0] rx_fill,
    input wire logic [1:0]         rx_trigger_sel,
    input wire logic               tx_serial, thr_write, core_irq_pending, other_irq_pending, other_sleep_en,
    input wire logic               cts_in_n, rts_out_n, tx_pin, tx_enable, osc_enable
);
    // shadow of gating settings, taken at the completing edge
    logic [7:0] efr_r, mcr_r;
    wire  [4:0] up_lvl = rx_trigger_sel == 2'h0 ? 5'h4 : rx_trigger_sel == 2'h1 ? 5'h8 : 5'he;
    wire        wr_ok  = avs_write && !avs_waitrequest && avs_byteenable[0];
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            efr_r <= '0;
            mcr_r <= '0;
        end else if (wr_ok && avs_address[5:2] == `UFC_OFS_EFR) begin
            efr_r <= avs_writedata[7:0];
        end else if (wr_ok && avs_address[5:2] == `UFC_OFS_MCR) begin
            mcr_r <= avs_writedata[7:0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
    sequence s_pulse; tx_pin [*3] ##1 !tx_pin; endsequence
    property p_ack; (avs_read || avs_write) && avs_waitrequest |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("bus answer out of time");
    property p_rts_off; efr_r[`UFC_EFR_AUTO_RTS] && rx_fill >= FIFO_AW'(up_lvl) |-> ##[0:3] rts_out_n; endproperty
    a_rts_off: assert property (p_rts_off) else $error("request line kept at upper fill");
    property p_cts; (efr_r[`UFC_EFR_AUTO_CTS] && cts_in_n) [*5] |-> !tx_enable; endproperty
    a_cts: assert property (p_cts) else $error("transmitter not stopped by clear line");
    property p_pend; (core_irq_pending || other_irq_pending) && osc_enable |=> osc_enable; endproperty
    a_pend: assert property (p_pend) else $error("sleep with interrupt pending");
    property p_both; !other_sleep_en && osc_enable |=> osc_enable; endproperty
    a_both: assert property (p_both) else $error("sleep without both channels enabled");
    property p_wake; !osc_enable && thr_write |-> ##[1:4] osc_enable; endproperty
    a_wake: assert property (p_wake) else $error("no wake on transmit write");
    property p_ir_pulse; mcr_r[`UFC_MCR_IR_EN] && $rose(tx_pin) |-> s_pulse; endproperty
    a_ir_pulse: assert property (p_ir_pulse) else $error("infrared pulse width wrong");
    property p_ir_idle; (mcr_r[`UFC_MCR_IR_EN] && tx_serial) [*8] |-> !tx_pin; endproperty
    a_ir_idle: assert property (p_ir_idle) else $error("infrared output not idle low");
endmodule
bind ufc_flow ufc_flow_properties #(.FIFO_AW(FIFO_AW)) ufc_flow_properties_i (.*);

// ==== bench/ufc_remote.sv ====
// remote serial device: answers the request line and sends start bits on command
`timescale 1ns/1ps
module ufc_remote (
    input  wire logic core_clk,
    input  wire logic rts_out_n,
    input  wire logic hold,
    input  wire logic go,
    input  wire logic idle_lvl,
    output logic      cts_in_n = 1'b1,
    output logic      rx_pin = 1'b1
);
    int n = 0;
    always @(posedge core_clk) begin
        cts_in_n <= hold;
        // a frame only starts while the request line asks for data
        if (go && !rts_out_n && n == 0) n <= 16;
        else if (n > 0) n <= n - 1;
        rx_pin <= (n > 0) ? !idle_lvl : idle_lvl;
    end
endmodule

// ==== bench/testbench.sv ====
// bench of the flow-control block
`timescale 1ns/1ps
`include "ufc_regs.svh"
module testbench;
    logic core_clk = 0, reset_n = 0, rd = 0, wr = 0, ser = 1, thw = 0, oirq = 0, osl = 0, cirq = 0;
    logic dsr = 1, hold = 0, go = 0, lvl = 1, done = 0, wt, rts_n, txp, rxd, txe, sto, sq, firq, osc, cts_n, rxp;
    logic [5:0] adr = 0;
    logic [31:0] wd = 0, got, rdat;
    logic [4:0] fill = 0;
    logic [1:0] tsel = 0;
    logic [3:0] be = 4'hf;
    logic [7:0] c, d, sd, sdt, lst;
    ufc_pkg::ufc_char_t rxc = '0;
    int errors = 0, n_compared = 0, nsto = 0, k, k0;
    ufc_flow ufc_flow_i (.core_clk(core_clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt), .sample_tick(1'b1),
        .rx_fill(fill), .rx_trigger_sel(tsel), .rx_char(rxc), .tx_char_done(done), .tx_shift_busy(1'b0),
        .tx_serial(ser), .thr_write(thw), .other_irq_pending(oirq), .other_sleep_en(osl), .core_irq_pending(cirq),
        .rx_pin(rxp), .cts_in_n(cts_n), .dsr_in_n(dsr), .carrier_detect_in_n(dsr), .ring_indicator_in_n(dsr),
        .rts_out_n(rts_n), .tx_pin(txp), .rx_data(rxd), .tx_enable(txe), .rx_store(sto), .rx_store_data(sd),
        .send_req(sq), .send_data(sdt), .flow_irq(firq), .osc_enable(osc));
    ufc_remote ufc_remote_i (.core_clk(core_clk), .rts_out_n(rts_n), .hold(hold), .go(go), .idle_lvl(lvl),
        .cts_in_n(cts_n), .rx_pin(rxp));
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (sto === 1'b1) begin nsto++; lst <= sd; end
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin #400000; errors++; end_sim(); end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] v);
        @(posedge core_clk);
        adr <= {i, 2'b00};
        wd <= 32'(v);
        wr <= w;
        rd <= !w;
        k = 0;
        do begin @(posedge core_clk); k++; end while (wt !== 1'b0 && k < 40);
        got = rdat;
        if (k >= 40) errors++;
        wr <= 0;
        rd <= 0;
    endtask
    task automatic rg(input logic [3:0] i, input logic [7:0] exp, input string what);
        bus(0, i, 0);
        chk(got, 32'(exp), what);
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic pk(input int n, ref logic s, input logic e, input string w);
        cy(n);
        chk(32'(s), 32'(e), w);
    endtask
    task automatic rx(input logic [7:0] v);
        @(posedge core_clk) rxc <= '{1'b1, v};
        @(posedge core_clk) rxc <= '0;
        cy(3);
    endtask
    task automatic pulse_thw();
        @(posedge core_clk) thw <= 1;
        @(posedge core_clk) thw <= 0;
    endtask
    function automatic logic [4:0] lvl_of(input int s, input bit up);
        return up ? 5'(s == 0 ? 4 : s == 1 ? 8 : 14) : 5'(s == 0 ? 0 : s == 1 ? 1 : s == 2 ? 4 : 8);
    endfunction
    initial begin
        void'($urandom(52));
        repeat (16) @(posedge core_clk);
        reset_n <= 1;
        for (logic [3:0] i = 6; i < 10; i++) rg(i, `UFC_CHAR_RST, "char reg");
        c = $urandom;
        d = c ^ 8'h0f;
        bus(1, 13, c);
        rg(13, 8'h00, "unmapped");
        for (logic [3:0] i = 6; i < 10; i++) begin
            bus(1, i, i < 8 ? d : c);
            rg(i, i < 8 ? d : c, "char reg");
        end
        bus(1, `UFC_OFS_MCR, 8'h02);
        bus(1, `UFC_OFS_IER, 8'h10);
        @(posedge core_clk) oirq <= 1;
        @(posedge core_clk) osl <= 1;
        bus(0, `UFC_OFS_MSR, 0);
        bus(0, `UFC_OFS_ISR, 0);
        pk(12, osc, 1, "osc");
        @(posedge core_clk) oirq <= 0;
        pk(12, osc, 0, "osc");
        pulse_thw();
        pk(0, osc, 1, "osc");
        pk(12, osc, 0, "osc");
        @(posedge core_clk) go <= 1;
        @(posedge core_clk) go <= 0;
        pk(8, osc, 1, "osc");
        pk(30, osc, 0, "osc");
        @(posedge core_clk) dsr <= 0;
        pk(8, osc, 1, "osc");
        pk(12, osc, 1, "osc");
        bus(0, `UFC_OFS_MSR, 0);
        pk(12, osc, 0, "osc");
        @(posedge core_clk) cirq <= 1;
        pulse_thw();
        pk(12, osc, 1, "osc");
        @(posedge core_clk) cirq <= 0;
        bus(1, `UFC_OFS_IER, 8'h00);
        pk(12, osc, 1, "osc");
        bus(1, `UFC_OFS_EFR, 8'h40);
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk) tsel <= 2'(s);
            @(posedge core_clk) fill <= lvl_of(s, 1);
            pk(4, rts_n, 1, "rts");
            @(posedge core_clk) fill <= lvl_of(s, 1) - 5'h1;
            pk(4, rts_n, 1, "rts");
            @(posedge core_clk) fill <= lvl_of(s, 0);
            pk(4, rts_n, 0, "rts");
        end
        bus(1, `UFC_OFS_EFR, 8'h80);
        @(posedge core_clk) hold <= 1;
        pk(8, txe, 0, "tx enable");
        @(posedge core_clk) hold <= 0;
        pk(8, txe, 1, "tx enable");
        bus(1, `UFC_OFS_EFR, 8'h00);
        for (int p = 0; p < 2; p++) begin
            bus(1, `UFC_OFS_LCR, p ? 8'h00 : 8'h03);
            bus(1, `UFC_OFS_IER, p ? 8'h00 : 8'h20);
            bus(1, `UFC_OFS_SWMODE, 8'h02);
            k0 = nsto;
            rx(p ? c ^ 8'he0 : c);
            pk(1, txe, 0, "tx enable");
            pk(0, firq, p == 0, "flow irq");
            rx(c ^ 8'h10);
            rx(d);
            pk(1, txe, 1, "tx enable");
            pk(0, firq, 0, "flow irq");
            chk(nsto - k0, 1, "stored count");
            chk(lst, c ^ 8'h10, "stored char");
        end
        bus(1, `UFC_OFS_SWMODE, 8'h00);
        bus(1, `UFC_OFS_EFR, 8'h20);
        rx(c);
        pk(0, firq, 1, "flow irq");
        chk(lst, c, "stored char");
        bus(1, `UFC_OFS_SWMODE, 8'h01);
        @(posedge core_clk) tsel <= 0;
        @(posedge core_clk) fill <= 1;
        pk(300, sq, 0, "send req");
        pk(40, sq, 1, "send req");
        chk(sdt, c, "send char");
        @(posedge core_clk) done <= 1;
        @(posedge core_clk) done <= 0;
        pk(3, sq, 0, "send req");
        @(posedge core_clk) fill <= 0;
        pk(8, sq, 1, "send req");
        chk(sdt, d, "send char");
        @(posedge core_clk) done <= 1;
        @(posedge core_clk) done <= 0;
        bus(1, `UFC_OFS_MCR, 8'h40);
        @(posedge core_clk) lvl <= 0;
        pk(6, txp, 0, "ir idle");
        pk(0, rxd, 1, "ir rx idle");
        @(posedge core_clk) ser <= 0;
        k0 = 0;
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            k0 += int'(txp);
            if (i == 15) ser <= 1;
        end
        chk(k0, `UFC_IR_TICKS, "ir pulse");
        bus(1, `UFC_OFS_MCR, 8'h44);
        @(posedge core_clk) lvl <= 1;
        pk(6, rxd, 1, "ir rx inverted");
        end_sim();
    end
endmodule
